// file: core/rls_map.vh
// Constants for the resolver link serial master
`ifndef RLS_MAP_VH
`define RLS_MAP_VH
`define RLS_CLK_HZ         250000000
`define RLS_BIT_RATE_BPS   1000000
`define RLS_HALF_DIV       ((`RLS_CLK_HZ / `RLS_BIT_RATE_BPS) / 2)
`define RLS_WORD_BITS      16
`define RLS_EDGES          (2 * `RLS_WORD_BITS)
`define RLS_LEAD_HALVES    2
`define RLS_TAIL_HALVES    2
`define RLS_GAP_HALVES     2
`define RLS_GAP_EXTRA_CLKS 2
`define RLS_SCK_IDLE       1'b1
`define RLS_SEL_IDLE       1'b1
`endif

// file: core/rls_buf2.v
// Two-entry valid/ready buffer for sixteen-bit words
`timescale 1ns/1ns
`default_nettype none
module rls_buf2
#(
  parameter W = 16
)
(
  // Clock and reset
  input  wire         i_clk,
  input  wire         i_sys_rst,
  // Fill side
  input  wire         i_in_valid,
  output wire         o_in_ready,
  input  wire [W-1:0] i_in_data,
  // Drain side
  output wire         o_out_valid,
  input  wire         i_out_ready,
  output wire [W-1:0] o_out_data
);
  reg [W-1:0] mem_reg [0:1];
  reg         wp_reg;
  reg         rp_reg;
  reg [1:0]   cnt_reg;
  wire        push;
  wire        pop;

  assign o_in_ready  = (cnt_reg != 2'h2);
  assign o_out_valid = (cnt_reg != 2'h0);
  assign o_out_data  = mem_reg[rp_reg];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always @(posedge i_clk)
  begin
    if (push)
    begin
      mem_reg[wp_reg] <= i_in_data;
    end
  end

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wp_reg <= ~wp_reg;
      end
      if (pop)
      begin
        rp_reg <= ~rp_reg;
      end
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// file: core/rls_halfdiv.v
// Divider giving one-cycle enables at twice the serial bit rate
`timescale 1ns/1ns
`default_nettype none
module rls_halfdiv
#(
  parameter DIV = 125
)
(
  // Clock and reset
  input  wire i_clk,
  input  wire i_sys_rst,
  // Control
  input  wire i_run,
  output wire o_tick
);
  reg [15:0] cnt_reg;

  // Restart on run so every phase begins with a full half period
  assign o_tick = i_run && (cnt_reg == DIV[15:0] - 16'h0001);

  always @(posedge i_clk)
  begin
    if (i_sys_rst || !i_run || o_tick)
    begin
      cnt_reg <= 16'h0000;
    end
    else
    begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// file: core/rls_master.v
// Serial master exchanging sixteen-bit words with a resolver converter
//
// Overview of operation
// - The block is master of a four-wire link driving clock, data out and select, reading data in.
// - The serial clock runs at one megabit per second derived from the system clock.
// - Outgoing frames hold only data bits, no parity bit is appended.
// - Incoming frames are not parity checked and no parity error is ever flagged.
// - One serial clock period passes from select assertion to the first clock edge.
// - Select stays asserted one serial clock period after the last clock edge.
// - Select stays inactive one serial clock period plus three system cycles between transfers.
// - No automatic clock stop: a full receive buffer does not pause transfers.
// - Idle data-in reads low, select zero is active low, selects one to three unused, loopback off.
// - Transmit-empty and receive-full requests tell software to move words.
// - Error and idle requests are raised, with error reporting enabled.
// - Each select assertion carries one sixteen-bit frame, most significant bit first.
// - Data changes on odd clock edges and is sampled on even clock edges.
// - The serial clock is high while no transfer runs.
// - All selects are released when each transfer completes.
`timescale 1ns/1ns
`default_nettype none
`include "rls_map.vh"
module rls_master
#(
  parameter WORD_BITS = `RLS_WORD_BITS,
  parameter HALF_DIV  = `RLS_HALF_DIV
)
(
  // Clock and reset
  input  wire                 i_clk,
  input  wire                 i_sys_rst,
  // Transmit words from software
  input  wire                 i_tx_valid,
  output wire                 o_tx_ready,
  input  wire [WORD_BITS-1:0] i_tx_data,
  // Receive words to software
  output wire                 o_rx_valid,
  input  wire                 i_rx_ready,
  output wire [WORD_BITS-1:0] o_rx_data,
  // Control
  input  wire                 i_err_enable,
  input  wire                 i_miso_connected,
  // Requests
  output wire                 o_transmit_empty_request,
  output wire                 o_receive_full_request,
  output reg                  o_error_request,
  output wire                 o_idle_request,
  output wire                 o_parity_error,
  // Serial link
  output reg                  o_serial_clock_out,
  output reg                  o_mosi,
  input  wire                 i_miso,
  output reg                  o_select_line_zero_n,
  output wire                 o_select_line_one_n,
  output wire                 o_select_line_two_n,
  output wire                 o_select_line_three_n
);
  // ********************************************************
  // State and storage
  // ********************************************************
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_LEAD = 3'h1;
  localparam [2:0] ST_XFER = 3'h2;
  localparam [2:0] ST_TAIL = 3'h3;
  localparam [2:0] ST_GAP  = 3'h4;
  localparam [2:0] ST_PAD  = 3'h5;

  reg  [2:0]           state_reg;
  reg  [2:0]           state_next;
  reg  [5:0]           edge_reg;
  reg  [1:0]           half_reg;
  reg  [1:0]           pad_reg;
  reg  [WORD_BITS-1:0] shift_reg;
  reg                  rx_push_reg;
  reg  [WORD_BITS-1:0] rx_word_reg;
  reg                  miss_reg;

  wire                 tick;
  wire                 run;
  wire                 txq_valid;
  wire [WORD_BITS-1:0] txq_data;
  wire                 txq_take;
  wire                 rxq_ready;
  wire                 miso_bit;

  // ********************************************************
  // Buffers and divider
  // ********************************************************
  rls_buf2 #(.W(WORD_BITS)) u_txq
  (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (i_tx_valid),
    .o_in_ready  (o_tx_ready),
    .i_in_data   (i_tx_data),
    .o_out_valid (txq_valid),
    .i_out_ready (txq_take),
    .o_out_data  (txq_data)
  );

  rls_buf2 #(.W(WORD_BITS)) u_rxq
  (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (rx_push_reg),
    .o_in_ready  (rxq_ready),
    .i_in_data   (rx_word_reg),
    .o_out_valid (o_rx_valid),
    .i_out_ready (i_rx_ready),
    .o_out_data  (o_rx_data)
  );

  rls_halfdiv #(.DIV(HALF_DIV)) u_div
  (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_run     (run),
    .o_tick    (tick)
  );

  assign run      = (state_reg != ST_IDLE) && (state_reg != ST_PAD);
  assign txq_take = (state_reg == ST_IDLE) && txq_valid;
  // Undriven data-in reads as low
  assign miso_bit = i_miso_connected ? i_miso : 1'b0;

  // ********************************************************
  // Requests and fixed pins
  // ********************************************************
  assign o_transmit_empty_request = o_tx_ready;
  assign o_receive_full_request   = o_rx_valid;
  assign o_idle_request           = (state_reg == ST_IDLE) && !txq_valid;
  // Frames carry data bits only, so there is nothing to check
  assign o_parity_error           = 1'b0;
  assign o_select_line_one_n      = `RLS_SEL_IDLE;
  assign o_select_line_two_n      = `RLS_SEL_IDLE;
  assign o_select_line_three_n    = `RLS_SEL_IDLE;

  // ********************************************************
  // Sequencer
  // ********************************************************
  // Phases: lead, edges, tail, gap in half periods, then pad in system cycles
  // Half counter restarts on every phase change, divider restarts with run
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (txq_valid)
        begin
          state_next = ST_LEAD;
        end
      end
      ST_LEAD:
      begin
        // First transfer tick makes the first edge, so lead ends one half early
        if (tick && half_reg == `RLS_LEAD_HALVES - 2)
        begin
          state_next = ST_XFER;
        end
      end
      ST_XFER:
      begin
        if (tick && edge_reg == `RLS_EDGES - 1)
        begin
          state_next = ST_TAIL;
        end
      end
      ST_TAIL:
      begin
        if (tick && half_reg == `RLS_TAIL_HALVES - 1)
        begin
          state_next = ST_GAP;
        end
      end
      ST_GAP:
      begin
        if (tick && half_reg == `RLS_GAP_HALVES - 1)
        begin
          state_next = ST_PAD;
        end
      end
      ST_PAD:
      begin
        if (pad_reg == `RLS_GAP_EXTRA_CLKS - 1)
        begin
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ********************************************************
  // Frame registers and pins
  // ********************************************************
  // Pins come from flip-flops so the link never sees decode glitches
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state_reg            <= ST_IDLE;
      edge_reg             <= 6'h00;
      half_reg             <= 2'h0;
      pad_reg              <= 2'h0;
      shift_reg            <= {WORD_BITS{1'b0}};
      rx_push_reg          <= 1'b0;
      rx_word_reg          <= {WORD_BITS{1'b0}};
      miss_reg             <= 1'b0;
      o_error_request      <= 1'b0;
      o_serial_clock_out   <= `RLS_SCK_IDLE;
      o_mosi               <= 1'b0;
      o_select_line_zero_n <= `RLS_SEL_IDLE;
    end
    else
    begin
      state_reg   <= state_next;
      rx_push_reg <= 1'b0;
      if (state_next != state_reg)
      begin
        half_reg <= 2'h0;
      end
      else if (tick)
      begin
        half_reg <= half_reg + 2'h1;
      end
      // Divider is stopped here, so pad counts plain system cycles
      pad_reg <= (state_reg == ST_PAD) ? pad_reg + 2'h1 : 2'h0;

      case (state_reg)
        ST_IDLE:
        begin
          o_serial_clock_out <= `RLS_SCK_IDLE;
          if (txq_valid)
          begin
            // Word loaded as is, first bit out before first edge
            shift_reg            <= txq_data;
            o_mosi               <= txq_data[WORD_BITS-1];
            o_select_line_zero_n <= 1'b0;
            edge_reg             <= 6'h00;
          end
        end
        ST_XFER:
        begin
          if (tick)
          begin
            edge_reg           <= edge_reg + 6'h01;
            o_serial_clock_out <= ~o_serial_clock_out;
            if (edge_reg[0])
            begin
              // Even edge: sample, MSB first
              shift_reg <= {shift_reg[WORD_BITS-2:0], miso_bit};
            end
            else if (edge_reg != 6'h00)
            begin
              // Odd edge past the first: next bit out
              o_mosi <= shift_reg[WORD_BITS-1];
            end
          end
        end
        ST_TAIL:
        begin
          if (tick && half_reg == 2'h0)
          begin
            // Frame done; receive side never stalls the link
            rx_word_reg <= shift_reg;
            rx_push_reg <= 1'b1;
            miss_reg    <= !rxq_ready;
          end
          if (tick && half_reg == `RLS_TAIL_HALVES - 1)
          begin
            o_select_line_zero_n <= `RLS_SEL_IDLE;
          end
        end
        default:
        begin
        end
      endcase

      // Overrun when the receive buffer cannot take a word
      if (rx_push_reg && miss_reg && i_err_enable)
      begin
        o_error_request <= 1'b1;
      end
      else if (state_reg == ST_LEAD)
      begin
        o_error_request <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/rls_master_properties.sv
// Timing checker for the resolver link serial master
`timescale 1ns/1ns
`default_nettype none
module rls_master_chk
#(
  parameter HALF_DIV = 125
)
(
  // Clock, reset and observed outputs
  input wire logic i_clk, i_sys_rst, o_tx_ready, o_rx_valid,
  input wire logic o_transmit_empty_request, o_receive_full_request,
  input wire logic o_idle_request, o_parity_error, o_serial_clock_out, o_mosi,
  input wire logic o_select_line_zero_n, o_select_line_one_n,
  input wire logic o_select_line_two_n, o_select_line_three_n
);
  wire        sel_n = o_select_line_zero_n;
  wire        sck   = o_serial_clock_out;
  reg         last_reg;
  reg  [15:0] low_reg;
  reg  [15:0] high_reg;
  reg  [15:0] since_reg;
  reg  [5:0]  edges_reg;
  wire        chg = sck != last_reg;
  // Gap counter saturates so an idle link never wraps into a false failure
  always @(posedge i_clk)
  begin
    last_reg  <= i_sys_rst | sck;
    low_reg   <= sel_n ? 16'h0000 : low_reg + 16'h0001;
    high_reg  <= i_sys_rst ? 16'hffff : !sel_n ? 16'h0000 : high_reg + {15'h0000, ~&high_reg};
    since_reg <= chg ? 16'h0001 : since_reg + 16'h0001;
    edges_reg <= sel_n ? 6'h00 : edges_reg + {5'h00, chg};
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sck_idle_a :
    assert property (sel_n |-> sck) else $error("clock low while deselected");
  lead_time_a :
    assert property ($fell(sck) && edges_reg == 6'h00 |-> low_reg == 2 * HALF_DIV)
    else $error("wrong lead before first clock edge");
  edge_space_a :
    assert property (chg && !sel_n && edges_reg != 6'h00 |-> since_reg == HALF_DIV)
    else $error("wrong clock half period");
  tail_time_a :
    assert property ($rose(sel_n) |-> since_reg == 2 * HALF_DIV && edges_reg == 6'h20)
    else $error("wrong tail or edge count");
  sel_gap_a :
    assert property ($fell(sel_n) |-> high_reg >= 2 * HALF_DIV + 2)
    else $error("select gap too short");
  data_hold_a :
    assert property ($rose(sck) |-> $stable(o_mosi)) else $error("data moved on sampling edge");
  unused_sel_a :
    assert property (o_select_line_one_n && o_select_line_two_n && o_select_line_three_n)
    else $error("unused select asserted");
  parity_off_a :
    assert property (!o_parity_error) else $error("parity error flagged");
  req_map_a :
    assert property (o_transmit_empty_request == o_tx_ready
      && o_receive_full_request == o_rx_valid) else $error("request mismatch");
  idle_req_a :
    assert property (o_idle_request |-> sel_n) else $error("idle while selected");
endmodule
bind rls_master rls_master_chk #(.HALF_DIV(HALF_DIV)) rls_master_chk_i (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .o_tx_ready(o_tx_ready), .o_rx_valid(o_rx_valid),
  .o_transmit_empty_request(o_transmit_empty_request),
  .o_receive_full_request(o_receive_full_request),
  .o_idle_request(o_idle_request), .o_parity_error(o_parity_error),
  .o_serial_clock_out(o_serial_clock_out), .o_mosi(o_mosi),
  .o_select_line_zero_n(o_select_line_zero_n), .o_select_line_one_n(o_select_line_one_n),
  .o_select_line_two_n(o_select_line_two_n), .o_select_line_three_n(o_select_line_three_n));
`default_nettype wire

// file: verif/rls_slave_model.sv
// Behavioural converter end of the serial link, mode 3
`timescale 1ns/1ns
`default_nettype none
module rls_slave_model
#(
  parameter INIT = 16'h5a3c
)
(
  input  wire logic        i_sck, i_mosi, i_sel_n,
  output var  logic        o_miso,
  output var  logic [15:0] o_got,
  output var  logic [4:0]  o_bits,
  output var  logic [7:0]  o_count
);
  reg [15:0] reply, sh;
  initial
  begin
    reply = INIT;
    o_miso = 1'b0;
    o_bits = 5'h00;
    o_count = 8'h00;
  end
  // Released line shows the inverse of its last value
  always @(negedge i_sel_n)
  begin
    sh = 16'h0000;
    o_bits = 5'h00;
    o_miso = ~o_miso;
  end
  always @(negedge i_sck) if (!i_sel_n) o_miso = reply[15 - o_bits];
  always @(posedge i_sck)
    if (!i_sel_n)
    begin
      sh = {sh[14:0], i_mosi};
      o_bits = o_bits + 5'h01;
    end
  always @(posedge i_sel_n)
    if (o_bits != 5'h00)
    begin
      o_got = sh;
      reply = ~sh;
      o_miso = ~o_miso;
      o_count = o_count + 8'h01;
    end
endmodule
`default_nettype wire

// file: verif/tb_rls_master.sv
// Self-checking bench for the resolver link serial master
`timescale 1ns/1ns
`default_nettype none
module tb_rls_master;
  reg clk = 0, rst = 1, tx_v = 0, rx_r = 1, err_en = 1, conn = 1;
  reg [15:0] tx_d = 16'h0000, rep = 16'h5a3c;
  wire tx_rdy, rx_v, te, rf, er, ir, pe, sck, mosi, miso, s0, s1, s2, s3;
  wire [15:0] rx_d, got;
  wire [4:0] bits;
  wire [7:0] cnt;
  integer fail_count = 0, check_count = 0, seed = 32'h2c12, cyc = 0, i;
  reg [15:0] exp_rx[$], exp_tx[$];
  rls_master #(.HALF_DIV(2)) rls_master_i (.i_clk(clk), .i_sys_rst(rst),
    .i_tx_valid(tx_v), .o_tx_ready(tx_rdy), .i_tx_data(tx_d), .o_rx_valid(rx_v),
    .i_rx_ready(rx_r), .o_rx_data(rx_d), .i_err_enable(err_en), .i_miso_connected(conn),
    .o_transmit_empty_request(te), .o_receive_full_request(rf), .o_error_request(er),
    .o_idle_request(ir), .o_parity_error(pe), .o_serial_clock_out(sck), .o_mosi(mosi),
    .i_miso(miso), .o_select_line_zero_n(s0), .o_select_line_one_n(s1),
    .o_select_line_two_n(s2), .o_select_line_three_n(s3));
  rls_slave_model rls_slave_model_i (.i_sck(sck), .i_mosi(mosi), .i_sel_n(s0),
    .o_miso(miso), .o_got(got), .o_bits(bits), .o_count(cnt));
  always #2 clk = ~clk;
  task cmp_word(input [15:0] g, input [15:0] e);
  begin
    check_count = check_count + 1;
    if (g !== e)
    begin
      fail_count = fail_count + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  end
  endtask
  task cmp_flag(input g, input e);
  begin
    cmp_word({15'h0000, g}, {15'h0000, e});
  end
  endtask
  task final_report;
  begin
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  // Holds valid from one word to the next so a burst never drops it
  task send(input [15:0] w);
  begin
    tx_v = 1;
    tx_d = w;
    exp_tx.push_back(w);
    exp_rx.push_back(conn ? rep : 16'h0000);
    rep = ~w;
    while (!tx_rdy) @(posedge clk) #1;
    @(posedge clk) #1;
  end
  endtask
  task wait_idle;
    integer k;
  begin
    k = 0;
    tx_v = 0;
    while (!(ir && s0 && exp_tx.size() == 0) && k < 2000)
    begin
      @(posedge clk) #1;
      k = k + 1;
    end
    cmp_flag(k < 2000, 1'b1);
  end
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      fail_count = fail_count + 1;
      final_report;
    end
  end
  always @(posedge clk) if (!rst && rx_v && rx_r) cmp_word(rx_d, exp_rx.pop_front());
  always @(cnt)
    if (cnt != 8'h00)
    begin
      cmp_word(got, exp_tx.pop_front());
      cmp_word({11'h000, bits}, 16'h0010);
    end
  initial
  begin
    repeat (10) @(posedge clk);
    #1 rst = 0;
    cmp_flag(te & ir & sck & s0 & ~rf & ~er, 1'b1);
    send(16'h8001);
    for (i = 0; i < 5; i = i + 1) send($random(seed));
    wait_idle;
    rx_r = 0;
    for (i = 0; i < 3; i = i + 1) send($random(seed));
    wait_idle;
    cmp_flag(er & rf, 1'b1);
    exp_rx.delete(2);
    rx_r = 1;
    repeat (4) @(posedge clk) #1;
    conn = 0;
    err_en = 0;
    send(16'hffff);
    wait_idle;
    cmp_flag(er | pe, 1'b0);
    cmp_word(exp_rx.size(), 16'h0000);
    final_report;
  end
endmodule
`default_nettype wire
